// ==== design/nis_pkg.sv ====
package nis_pkg;

    // ------------------------------------------------------------
    // Register bus geometry
    // ------------------------------------------------------------
    localparam int NIS_AW = 8;
    localparam int NIS_DW = 32;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] NIS_OFS_SWITCH = 8'h00; // Captured switch number, read only
    localparam logic [7:0] NIS_OFS_SOFT = 8'h04; // Software station number, read/write
    localparam logic [7:0] NIS_OFS_ACTIVE = 8'h08; // Active station number, read only
    localparam logic [7:0] NIS_OFS_IP = 8'h0C; // IP address, read/write
    localparam logic [7:0] NIS_OFS_IPSTAT = 8'h10; // IP address status, read only
    localparam logic [7:0] NIS_OFS_MAC_LO = 8'h14; // Ethernet address bits 31:0
    localparam logic [7:0] NIS_OFS_MAC_HI = 8'h18; // Ethernet address bits 47:32
    localparam logic [7:0] NIS_OFS_CTRL = 8'h1C; // Protocol select, read/write

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int NIS_SW_CAPT_BIT = 8; // SWITCH: capture done
    localparam int NIS_SW_MAST_BIT = 9; // SWITCH: role is master
    localparam int NIS_ACT_SOFT_BIT = 16; // ACTIVE: software number in use
    localparam int NIS_ACT_VALID_BIT = 17; // ACTIVE: identifier valid
    localparam int NIS_IPS_DEF_BIT = 0; // IPSTAT: still the default
    localparam int NIS_IPS_OK_BIT = 1; // IPSTAT: usable
    localparam int NIS_IPS_BAD_BIT = 2; // IPSTAT: partly changed
    localparam int NIS_CTRL_UDP_BIT = 0; // CTRL: 1 = UDP/IP, 0 = IPX

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [15:0] NIS_SOFT_RESET = 16'h0000;
    localparam logic [31:0] NIS_IP_RESET = 32'hFFFFFFFF;
    localparam logic [7:0] NIS_OCTET_UNSET = 8'hFF;
    localparam logic [5:0] NIS_SW_MAX = 6'h3F;
    localparam logic [15:0] NIS_MASTER_NUMBER = 16'h0000;

    // ------------------------------------------------------------
    // Timing: cycles to let the switch synchroniser fill after reset
    // ------------------------------------------------------------
    localparam logic [1:0] NIS_SETTLE_CYCLES = 2'h3;

    // ------------------------------------------------------------
    // Lookup key kinds
    // ------------------------------------------------------------
    localparam logic [1:0] NIS_KEY_NUMBER = 2'h0;
    localparam logic [1:0] NIS_KEY_IP = 2'h1;
    localparam logic [1:0] NIS_KEY_MAC = 2'h2;
    localparam logic [1:0] NIS_KEY_NAME = 2'h3;

    // ------------------------------------------------------------
    // Capture sequencer states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        NIS_ST_SETTLE,
        NIS_ST_RUN
    } nis_state_type;

endpackage

// ==== design/nis_sync.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Two flip-flop synchroniser for a group of pin levels
// ------------------------------------------------------------
module nis_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);

    // First stage, read only by the second stage
    logic [WIDTH-1:0] meta_q;
    // Second stage, safe to use
    logic [WIDTH-1:0] sync_q;

    // Both stages clear on reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign level_out = sync_q;

endmodule

// ==== design/nis_ident.sv ====
`timescale 1ns/100ps
// What this block does
// - Switch number for slaves spans one to 63
// - Number is sum of ON switch weights
// - Switch n weighs two to power n
// - Software number is sixteen bits wide
// - Software number only while switches read zero
// - Capture switch number at power-up
// - IP resets to all ones, unusable
// - Any octet 255 makes IP invalid
// - Expose 48-bit Ethernet address
// - Ethernet address fixed, never altered
// - Never match a slave by name
// - IPX uses number or MAC; IP needs UDP
// - Identifier kinds may mix per lookup
module nis_ident
    import nis_pkg::*;
#(
    parameter logic [47:0] MAC_ADDRESS = 48'h0A1B2C3D4E5F // Arbitrary value
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [5:0] switch_pins,
    input wire logic io_master_pin,
    input wire logic [NIS_AW-1:0] reg_addr,
    input wire logic [NIS_DW-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [NIS_DW-1:0] reg_rdata,
    input wire logic key_valid,
    input wire logic [1:0] key_kind,
    input wire logic [47:0] key_value,
    output logic key_done,
    output logic key_match,
    output logic [15:0] station_number,
    output logic id_valid,
    output logic [31:0] ip_address,
    output logic ip_usable,
    output logic proto_udp,
    output logic [47:0] mac_address
);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------

    logic [6:0] pins_sync; // Synchronised switches and role strap

    nis_sync #(.WIDTH(7)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .pin_in({io_master_pin, switch_pins}),
        .level_out(pins_sync)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------

    nis_state_type state_q; // Capture sequencer
    logic [1:0] settle_q; // Settling counter
    logic captured_q; // Switches have been latched
    logic [5:0] switch_number_q; // Latched switch number
    logic io_master_q; // Latched role
    logic [15:0] soft_number_q; // Software station number
    logic [31:0] ip_q; // IP address
    logic udp_q; // Protocol select
    logic [NIS_DW-1:0] rdata_q; // Read data
    logic done_q; // Lookup answer strobe
    logic match_q; // Lookup answer

    // ------------------------------------------------------------
    // Switch weighting
    // ------------------------------------------------------------

    logic [5:0] switch_sum; // Sum of weights of ON switches

    // Each ON switch adds its power-of-two weight
    always_comb begin
        switch_sum = 6'h00;
        for (int i = 0; i < 6; i++) begin
            if (pins_sync[i]) begin
                switch_sum = switch_sum + 6'(1 << i);
            end
        end
    end

    // ------------------------------------------------------------
    // Capture after reset
    // ------------------------------------------------------------

    wire load_now = (state_q == NIS_ST_SETTLE) && (settle_q == NIS_SETTLE_CYCLES);

    // Wait for the synchroniser, then latch once
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q <= NIS_ST_SETTLE;
            settle_q <= 2'h0;
            captured_q <= 1'b0;
            switch_number_q <= 6'h00;
            io_master_q <= 1'b0;
        end else begin
            unique case (state_q)
                NIS_ST_SETTLE: begin
                    // Count settling cycles, then capture
                    if (load_now) begin
                        state_q <= NIS_ST_RUN;
                        captured_q <= 1'b1;
                        switch_number_q <= switch_sum;
                        io_master_q <= pins_sync[6];
                    end else begin
                        settle_q <= settle_q + 2'h1;
                    end
                end
                NIS_ST_RUN: begin
                    // Hold until next reset, switches ignored
                    state_q <= NIS_ST_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Active identifier selection
    // ------------------------------------------------------------

    wire sw_nonzero = (switch_number_q != 6'h00);
    wire soft_loaded = (soft_number_q != 16'h0000);
    wire use_soft = !io_master_q && !sw_nonzero && soft_loaded;
    wire [15:0] sw_wide = {10'h000, switch_number_q};
    // Master is zero, switches win, else software number
    wire [15:0] active_number = io_master_q ? NIS_MASTER_NUMBER :
        (sw_nonzero ? sw_wide : soft_number_q);
    // Valid once captured; a slave must not sit at zero
    wire active_ok = captured_q && (io_master_q || (active_number != 16'h0000));

    // ------------------------------------------------------------
    // IP address checks
    // ------------------------------------------------------------

    logic [3:0] octet_unset; // Octet still at 255

    // Flag every octet that still holds the default
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            octet_unset[i] = (ip_q[8*i +: 8] == NIS_OCTET_UNSET);
        end
    end

    wire ip_default = &octet_unset;
    wire ip_ok = ~|octet_unset;
    wire ip_partial = |octet_unset && !ip_default;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------

    wire hit_switch = (reg_addr == NIS_OFS_SWITCH);
    wire hit_soft = (reg_addr == NIS_OFS_SOFT);
    wire hit_active = (reg_addr == NIS_OFS_ACTIVE);
    wire hit_ip = (reg_addr == NIS_OFS_IP);
    wire hit_ipstat = (reg_addr == NIS_OFS_IPSTAT);
    wire hit_mac_lo = (reg_addr == NIS_OFS_MAC_LO);
    wire hit_mac_hi = (reg_addr == NIS_OFS_MAC_HI);
    wire hit_ctrl = (reg_addr == NIS_OFS_CTRL);

    logic [NIS_DW-1:0] word_switch; // SWITCH contents
    logic [NIS_DW-1:0] word_active; // ACTIVE contents
    logic [NIS_DW-1:0] word_ipstat; // IPSTAT contents

    // Pack status words
    always_comb begin
        word_switch = '0;
        word_switch[5:0] = switch_number_q;
        word_switch[NIS_SW_CAPT_BIT] = captured_q;
        word_switch[NIS_SW_MAST_BIT] = io_master_q;
        word_active = '0;
        word_active[15:0] = active_number;
        word_active[NIS_ACT_SOFT_BIT] = use_soft;
        word_active[NIS_ACT_VALID_BIT] = active_ok;
        word_ipstat = '0;
        word_ipstat[NIS_IPS_DEF_BIT] = ip_default;
        word_ipstat[NIS_IPS_OK_BIT] = ip_ok;
        word_ipstat[NIS_IPS_BAD_BIT] = ip_partial;
    end

    // Read mux; unmapped offsets read zero
    wire [NIS_DW-1:0] read_word =
        hit_switch ? word_switch :
        hit_soft ? {16'h0000, soft_number_q} :
        hit_active ? word_active :
        hit_ip ? ip_q :
        hit_ipstat ? word_ipstat :
        hit_mac_lo ? MAC_ADDRESS[31:0] :
        hit_mac_hi ? {16'h0000, MAC_ADDRESS[47:32]} :
        hit_ctrl ? {31'h00000000, udp_q} : '0;

    // ------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------

    // Software number, IP and protocol; the Ethernet address has no write path
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            soft_number_q <= NIS_SOFT_RESET;
            ip_q <= NIS_IP_RESET;
            udp_q <= 1'b0;
        end else if (reg_write) begin
            if (hit_soft) begin
                soft_number_q <= reg_wdata[15:0];
            end
            if (hit_ip) begin
                ip_q <= reg_wdata;
            end
            if (hit_ctrl) begin
                udp_q <= reg_wdata[NIS_CTRL_UDP_BIT];
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= reg_read ? read_word : '0;
        end
    end

    // ------------------------------------------------------------
    // Identifier lookup
    // ------------------------------------------------------------

    // Number only under IPX, and only while valid
    wire num_hit = !udp_q && active_ok && (key_value == {32'h00000000, active_number});
    // IP only under UDP with a usable address
    wire ip_hit = udp_q && ip_ok && (key_value == {16'h0000, ip_q});
    // Ethernet address under IPX
    wire mac_hit = !udp_q && (key_value == MAC_ADDRESS);
    // Each lookup carries its own kind; a name never matches
    wire kind_hit = (key_kind == NIS_KEY_NUMBER) ? num_hit :
        (key_kind == NIS_KEY_IP) ? ip_hit :
        (key_kind == NIS_KEY_MAC) ? mac_hit : 1'b0;

    // Answer one cycle after the key
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            done_q <= 1'b0;
            match_q <= 1'b0;
        end else begin
            done_q <= key_valid;
            match_q <= key_valid && kind_hit;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    assign reg_rdata = rdata_q;
    assign key_done = done_q;
    assign key_match = match_q;
    assign station_number = active_number;
    assign id_valid = active_ok;
    assign ip_address = ip_q;
    assign ip_usable = ip_ok;
    assign proto_udp = udp_q;
    assign mac_address = MAC_ADDRESS;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    property p_sw_range;
        @(posedge clock) disable iff (!rst_n)
        (captured_q && !io_master_q && sw_nonzero) |->
            (station_number >= 16'h0001) && (station_number <= 16'h003F);
    endproperty
    a_sw_range: assert property (p_sw_range) else $error("switch number out of range");

    property p_sw_sum;
        @(posedge clock) disable iff (!rst_n)
        $rose(captured_q) |-> (switch_number_q == $past(pins_sync[5:0]));
    endproperty
    a_sw_sum: assert property (p_sw_sum) else $error("captured number not switch sum");

    property p_sw_max;
        @(posedge clock) disable iff (!rst_n)
        (load_now && (pins_sync[5:0] == NIS_SW_MAX)) |=> (switch_number_q == NIS_SW_MAX);
    endproperty
    a_sw_max: assert property (p_sw_max) else $error("all switches on not 63");

    property p_soft_write;
        @(posedge clock) disable iff (!rst_n)
        (reg_write && hit_soft) |=> (soft_number_q == $past(reg_wdata[15:0]));
    endproperty
    a_soft_write: assert property (p_soft_write) else $error("soft number not stored");

    property p_sw_wins;
        @(posedge clock) disable iff (!rst_n)
        (captured_q && !io_master_q && sw_nonzero) |->
            (station_number == sw_wide) && !use_soft;
    endproperty
    a_sw_wins: assert property (p_sw_wins) else $error("switches did not override");

    property p_capture_once;
        @(posedge clock) disable iff (!rst_n)
        captured_q |=> captured_q && $stable(switch_number_q) ##1 $stable(switch_number_q);
    endproperty
    a_capture_once: assert property (p_capture_once) else $error("number moved");

    property p_capture_time;
        @(posedge clock) disable iff (!rst_n)
        $rose(rst_n) |-> !captured_q ##[1:5] captured_q;
    endproperty
    a_capture_time: assert property (p_capture_time) else $error("capture not done");

    property p_ip_reset;
        @(posedge clock) disable iff (!rst_n)
        $rose(rst_n) |-> (ip_address == NIS_IP_RESET) && !ip_usable;
    endproperty
    a_ip_reset: assert property (p_ip_reset) else $error("IP not default at reset");

    property p_ip_octet;
        @(posedge clock) disable iff (!rst_n)
        (ip_address[31:24] == 8'hFF || ip_address[23:16] == 8'hFF ||
         ip_address[15:8] == 8'hFF || ip_address[7:0] == 8'hFF) |-> !ip_usable;
    endproperty
    a_ip_octet: assert property (p_ip_octet) else $error("IP with 255 octet usable");

    property p_mac_fixed;
        @(posedge clock) disable iff (!rst_n)
        reg_write |=> (mac_address == $past(mac_address));
    endproperty
    a_mac_fixed: assert property (p_mac_fixed) else $error("Ethernet address changed");

    property p_no_name;
        @(posedge clock) disable iff (!rst_n)
        (key_valid && key_kind == NIS_KEY_NAME) |=> key_done && !key_match;
    endproperty
    a_no_name: assert property (p_no_name) else $error("name lookup matched");

    property p_ip_needs_udp;
        @(posedge clock) disable iff (!rst_n)
        (key_valid && key_kind == NIS_KEY_IP && !proto_udp) |=> !key_match;
    endproperty
    a_ip_needs_udp: assert property (p_ip_needs_udp) else $error("IP hit under IPX");

    property p_zero_invalid;
        @(posedge clock) disable iff (!rst_n)
        (captured_q && !io_master_q && station_number == 16'h0000) |-> !id_valid;
    endproperty
    a_zero_invalid: assert property (p_zero_invalid) else $error("zero slave valid");

    c_capture: cover property (@(posedge clock) disable iff (!rst_n) $rose(captured_q));
    c_soft_used: cover property (@(posedge clock) disable iff (!rst_n) use_soft && id_valid);
    c_ip_match: cover property (@(posedge clock) disable iff (!rst_n)
        key_match && $past(key_kind) == NIS_KEY_IP);
    c_mac_match: cover property (@(posedge clock) disable iff (!rst_n)
        key_match && $past(key_kind) == NIS_KEY_MAC);

endmodule

// ==== verification/nis_switch_model.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Slide switches and role strap seen from the board side
// ------------------------------------------------------------
module nis_switch_model (
    input wire logic clock,
    input wire logic [5:0] sw_set,
    input wire logic master_set,
    output logic [5:0] switch_pins,
    output logic io_master_pin
);
    // Contacts settle one edge after the hand moves them
    always_ff @(posedge clock) begin
        switch_pins <= sw_set;
        io_master_pin <= master_set;
    end
endmodule

// ==== verification/network_identifier_select_test.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Self-checking bench for the identifier block
// ------------------------------------------------------------
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin \
    $display("Error %s expected %h seen %h", nm, exp, got); fails++; end end
module network_identifier_select_test;
    import nis_pkg::*;
    localparam logic [47:0] MAC = 48'h123456789ABC; // Arbitrary value
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] sw_set = 6'h00;
    logic master_set = 1'b0;
    logic [5:0] switch_pins;
    logic io_master_pin;
    logic [NIS_AW-1:0] reg_addr = '0;
    logic [NIS_DW-1:0] reg_wdata = '0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [NIS_DW-1:0] reg_rdata;
    logic key_valid = 1'b0;
    logic [1:0] key_kind = 2'h0;
    logic [47:0] key_value = '0;
    logic key_done, key_match, id_valid, ip_usable, proto_udp;
    logic [15:0] station_number;
    logic [31:0] ip_address;
    logic [47:0] mac_address;
    logic [31:0] d;
    int fails = 0;
    int n_checks = 0;
    // ------------------------------------------------------------
    // Clock, far side and device
    // ------------------------------------------------------------
    always #4 clock = ~clock;
    nis_switch_model sw_u (.clock(clock), .sw_set(sw_set), .master_set(master_set),
        .switch_pins(switch_pins), .io_master_pin(io_master_pin));
    nis_ident #(.MAC_ADDRESS(MAC)) dut_u (.clock(clock), .rst_n(rst_n),
        .switch_pins(switch_pins), .io_master_pin(io_master_pin), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .key_valid(key_valid), .key_kind(key_kind),
        .key_value(key_value), .key_done(key_done), .key_match(key_match),
        .station_number(station_number), .id_valid(id_valid), .ip_address(ip_address),
        .ip_usable(ip_usable), .proto_udp(proto_udp), .mac_address(mac_address));
    // ------------------------------------------------------------
    // Bus, lookup and reset helpers
    // ------------------------------------------------------------
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask
    // Read data stand in the cycle after the strobe only
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic look(input logic [1:0] k, input logic [47:0] v, output logic m);
        @(posedge clock);
        key_valid <= 1'b1;
        key_kind <= k;
        key_value <= v;
        @(posedge clock);
        key_valid <= 1'b0;
        #1;
        `CHK("key_done", 1'b1, key_done)
        m = key_match;
    endtask
    // Reset with a switch setting, then wait for the capture flag
    task automatic do_reset(input logic [5:0] sw, input logic mst);
        logic [31:0] s;
        @(posedge clock);
        sw_set <= sw;
        master_set <= mst;
        rst_n <= 1'b0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            rd(NIS_OFS_SWITCH, s);
            if (s[NIS_SW_CAPT_BIT] === 1'b1) return;
        end
        $display("Error capture flag never set");
        fails++;
        wrap_up();
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_capture();
        do_reset(6'h0E, 1'b0);
        `CHK("station", 16'h000E, station_number)
        `CHK("id_valid", 1'b1, id_valid)
        rd(NIS_OFS_SWITCH, d);
        `CHK("switch word", 32'h0000010E, d)
        `CHK("ip", 32'hFFFFFFFF, ip_address)
        `CHK("ip_usable", 1'b0, ip_usable)
        rd(NIS_OFS_IPSTAT, d);
        `CHK("ipstat", 32'h00000001, d)
        `CHK("mac", MAC, mac_address)
        sw_set <= 6'h01;
        repeat (6) @(posedge clock);
        #1;
        `CHK("station held", 16'h000E, station_number)
        wr(NIS_OFS_SOFT, 32'h00000005);
        `CHK("station over soft", 16'h000E, station_number)
        rd(NIS_OFS_ACTIVE, d);
        `CHK("active word", 32'h0002000E, d)
        $display("Test capture done");
    endtask
    task automatic t_weights();
        for (int i = 0; i < 6; i++) begin
            do_reset(6'(1 << i), 1'b0);
            `CHK("weight", 16'(1 << i), station_number)
        end
        do_reset(6'h3F, 1'b0);
        `CHK("max", 16'h003F, station_number)
        $display("Test weights done");
    endtask
    task automatic t_soft();
        do_reset(6'h00, 1'b0);
        `CHK("id_valid zero", 1'b0, id_valid)
        wr(NIS_OFS_SOFT, 32'h0000FFFF);
        `CHK("soft station", 16'hFFFF, station_number)
        `CHK("soft valid", 1'b1, id_valid)
        rd(NIS_OFS_ACTIVE, d);
        `CHK("soft active", 32'h0003FFFF, d)
        wr(NIS_OFS_SOFT, 32'h00000000);
        `CHK("unloaded", 1'b0, id_valid)
        do_reset(6'h00, 1'b1);
        `CHK("master number", 16'h0000, station_number)
        `CHK("master valid", 1'b1, id_valid)
        $display("Test soft done");
    endtask
    task automatic t_ip_regs();
        do_reset(6'h0E, 1'b0);
        wr(NIS_OFS_IP, 32'hFFA86402);
        `CHK("partial usable", 1'b0, ip_usable)
        rd(NIS_OFS_IPSTAT, d);
        `CHK("partial stat", 32'h00000004, d)
        wr(NIS_OFS_IP, 32'hC0A86402);
        `CHK("good usable", 1'b1, ip_usable)
        `CHK("good ip", 32'hC0A86402, ip_address)
        rd(NIS_OFS_IPSTAT, d);
        `CHK("good stat", 32'h00000002, d)
        wr(NIS_OFS_IP, 32'hC0A864FF);
        `CHK("low octet 255", 1'b0, ip_usable)
        wr(NIS_OFS_IP, 32'hC0A86402);
        wr(NIS_OFS_MAC_LO, 32'h00000000);
        wr(NIS_OFS_MAC_HI, 32'h00000000);
        rd(NIS_OFS_MAC_LO, d);
        `CHK("mac lo", MAC[31:0], d)
        rd(NIS_OFS_MAC_HI, d);
        `CHK("mac hi", {16'h0000, MAC[47:32]}, d)
        wr(NIS_OFS_ACTIVE, 32'h00000009);
        `CHK("ro station", 16'h000E, station_number)
        rd(8'h40, d);
        `CHK("unmapped", 32'h00000000, d)
        $display("Test ip_regs done");
    endtask
    // Every key kind under both protocols; the station stays 14
    task automatic t_lookup();
        logic [1:0] kinds [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
        logic [47:0] vals [5] = '{48'hE, 48'hF, 48'hC0A86402, MAC, 48'hE};
        logic exp_ipx [5] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        logic exp_udp [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
        logic m;
        for (int i = 0; i < 5; i++) begin
            look(kinds[i], vals[i], m);
            `CHK("ipx match", exp_ipx[i], m)
        end
        wr(NIS_OFS_CTRL, 32'h00000001);
        `CHK("udp", 1'b1, proto_udp)
        for (int i = 0; i < 5; i++) begin
            look(kinds[i], vals[i], m);
            `CHK("udp match", exp_udp[i], m)
        end
        $display("Test lookup done");
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        t_capture();
        t_weights();
        t_soft();
        t_ip_regs();
        t_lookup();
        wrap_up();
    end
endmodule
